/* rtl/smc_map.svh */
/*
  constants of the serial mode block: register offsets, field positions,
  reset values and status bit positions.
  assumes a system clock of 20 MHz and an 8-bit register port.
*/
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// register offsets
`define SMC_OFF_MODE 4'h0
`define SMC_OFF_CTRL 4'h1
`define SMC_OFF_EXT 4'h2
`define SMC_OFF_STAT 4'h3
`define SMC_OFF_MASK 4'h4
`define SMC_OFF_DATA 4'h5

// serial_mode_config fields
`define SMC_MODE_ORDER 7
`define SMC_MODE_STALL 6
`define SMC_MODE_RATE_HI 5
`define SMC_MODE_RATE_LO 3
`define SMC_MODE_BC_HI 2
`define SMC_MODE_BC_LO 0
`define SMC_MODE_RESET 8'h00

// bus_control_reg fields
`define SMC_CTRL_ENABLE 7
`define SMC_CTRL_MASTER 5
`define SMC_CTRL_START 1
`define SMC_CTRL_FORMAT 0
`define SMC_CTRL_RESET 8'h00

// timer_serial_ctrl_reg field
`define SMC_EXT_RANGE 0

// status / mask bits
`define SMC_ST_XFER 0
`define SMC_ST_STALL 1
`define SMC_ST_DENIED 2
`define SMC_ST_W 3

`endif

/* rtl/smc_pkg.sv */
/*
  types shared by the serial mode block.
  assumes nothing beyond a sv-2012 compiler.
*/
package smc_pkg;
  typedef enum logic [4:0] {
    SMC_IDLE  = 5'b00001,
    SMC_LOW   = 5'b00010,
    SMC_HIGH  = 5'b00100,
    SMC_STALL = 5'b01000,
    SMC_DONE  = 5'b10000
  } smc_state_e;
endpackage

/* rtl/smc_rate_div.sv */
/*
  serial clock half-period tick generator from the rate code and range bit.
  assumes the rate inputs stay stable during a frame.
*/
`timescale 1ns/1ps
`include "smc_map.svh"

module smc_rate_div (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic run,
  input wire logic range_ext,
  input wire logic [2:0] rate_code,
  // half-period tick
  output logic half_tick
);
  logic [8:0] divisor;
  logic [7:0] count;

  // full serial clock divisor; nine bits so the slowest code of 256 fits
  always_comb begin
    unique case ({range_ext, rate_code})
      4'h0: divisor = 9'h01c;
      4'h1: divisor = 9'h028;
      4'h2: divisor = 9'h030;
      4'h3: divisor = 9'h040;
      4'h4: divisor = 9'h050;
      4'h5: divisor = 9'h064;
      4'h6: divisor = 9'h070;
      4'h7: divisor = 9'h080;
      4'h8: divisor = 9'h038;
      4'h9: divisor = 9'h050;
      4'ha: divisor = 9'h060;
      4'hb: divisor = 9'h080;
      4'hc: divisor = 9'h0a0;
      4'hd: divisor = 9'h0c8;
      4'he: divisor = 9'h0e0;
      default: divisor = 9'h100;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 8'h00;
      half_tick <= 1'b0;
    end else if (!run) begin
      count <= 8'h00;
      half_tick <= 1'b0;
    end else if (count >= divisor[8:1] - 8'h01) begin
      count <= 8'h00;
      half_tick <= 1'b1;
    end else begin
      count <= count + 8'h01;
      half_tick <= 1'b0;
    end
  end
endmodule

/* rtl/smc_bit_count.sv */
/*
  maps the bit count code to the frame length for the selected format.
  assumes fmt_sync is high for the clocked synchronous format.
*/
`timescale 1ns/1ps
`include "smc_map.svh"

module smc_bit_count (
  // selection
  input wire logic [2:0] code,
  input wire logic fmt_sync,
  // frame length
  output logic [3:0] bits
);
  logic [3:0] sync_bits;

  // code 000 is 8, others code value; bus format adds the ack bit
  assign sync_bits = (code == 3'h0) ? 4'h8 : {1'b0, code}; // R9 R10 R11
  assign bits = fmt_sync ? sync_bits : sync_bits + 4'h1; // R11
endmodule

/* rtl/smc_top.sv */
/*
  mode register of a two-wire serial interface with a small master shifter
  that uses its bit order, ack stall, rate and bit count fields.
  assumes a single 20 MHz clock, synchronous register strobes and pins.
*/
// How it works
// R1 - the mode register is read or written only while iface_enable is 1.
// R2 - bit_order_select 0 shifts msb first and 1 shifts lsb first; software keeps 0 on the bus.
// R3 - the ack stall bit counts only for a master in the bus format.
// R4 - with ack stall on, the flag sets after the last data clock fall and scl stays low.
// R5 - clearing the transfer flag during the stall resumes with the ack bit.
// R6 - with ack stall off, data and ack bits run back to back.
// R7 - the transfer flag sets at the end of every transfer.
// R8 - rate code plus range bit pick the divider, used only by a master.
// R9 - code 000 gives 9 bits on the bus format and 8 in synchronous format.
// R10 - code 001 gives 2 bits on the bus format and 1 in synchronous format.
// R11 - higher codes add one bit per step, the bus format always one more.
// R12 - reset clears every field of the mode register.
`timescale 1ns/1ps
`include "smc_map.svh"

module smc_top (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // serial pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // interrupt
  output logic irq
);
  logic [7:0] serial_mode_config;
  logic [7:0] bus_control_reg;
  logic [7:0] timer_serial_ctrl_reg;
  logic [`SMC_ST_W-1:0] status;
  logic [`SMC_ST_W-1:0] mask;
  logic [7:0] shift;
  logic [3:0] bit_idx;
  logic transfer_irq_flag;
  smc_pkg::smc_state_e state;

  logic iface_enable;
  logic bit_order_select;
  logic stall_en;
  logic fmt_sync;
  logic master;
  logic mode_ok;
  logic half_tick;
  logic [3:0] frame_bits;
  logic [3:0] data_bits;
  logic last_bit;
  logic xfer_done;
  logic stall_enter;
  logic clr_flag;
  logic start_req;
  logic [`SMC_ST_W-1:0] events;
  logic [7:0] next_rdata;

  assign iface_enable = bus_control_reg[`SMC_CTRL_ENABLE];
  assign master = bus_control_reg[`SMC_CTRL_MASTER];
  assign fmt_sync = bus_control_reg[`SMC_CTRL_FORMAT];
  assign bit_order_select = serial_mode_config[`SMC_MODE_ORDER];
  assign mode_ok = iface_enable && ((addr == `SMC_OFF_MODE) || (addr == `SMC_OFF_DATA));
  assign stall_en = serial_mode_config[`SMC_MODE_STALL] && master && !fmt_sync; // R3
  assign data_bits = fmt_sync ? frame_bits : frame_bits - 4'h1;
  assign last_bit = (bit_idx == frame_bits - 4'h1);
  assign start_req = wr && (addr == `SMC_OFF_CTRL) && wdata[`SMC_CTRL_START]
                     && wdata[`SMC_CTRL_ENABLE] && wdata[`SMC_CTRL_MASTER];
  assign clr_flag = wr && (addr == `SMC_OFF_CTRL) && !wdata[`SMC_CTRL_START];

  smc_bit_count u_bits (
    .code(serial_mode_config[`SMC_MODE_BC_HI:`SMC_MODE_BC_LO]),
    .fmt_sync(fmt_sync),
    .bits(frame_bits)
  );

  // divider only runs for a master with an active frame
  smc_rate_div u_div (
    .clk(clk),
    .arst_n(arst_n),
    .run(master && (state == smc_pkg::SMC_LOW || state == smc_pkg::SMC_HIGH)), // R8
    .range_ext(timer_serial_ctrl_reg[`SMC_EXT_RANGE]),
    .rate_code(serial_mode_config[`SMC_MODE_RATE_HI:`SMC_MODE_RATE_LO]), // R8
    .half_tick(half_tick)
  );

  // mode register, writable only when enabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_mode_config <= `SMC_MODE_RESET; // R12
    end else if (wr && mode_ok && addr == `SMC_OFF_MODE) begin // R1
      serial_mode_config <= wdata;
    end
  end

  // control and range registers; start bit is self clearing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_control_reg <= `SMC_CTRL_RESET;
      timer_serial_ctrl_reg <= 8'h00;
    end else begin
      if (wr && addr == `SMC_OFF_CTRL) begin
        bus_control_reg <= {wdata[7:2], 1'b0, wdata[0]};
      end
      if (wr && addr == `SMC_OFF_EXT) begin
        timer_serial_ctrl_reg <= {7'h00, wdata[`SMC_EXT_RANGE]};
      end
    end
  end

  // bit index and end-of-data detection
  assign xfer_done = (state == smc_pkg::SMC_HIGH) && half_tick && last_bit;
  assign stall_enter = (state == smc_pkg::SMC_HIGH) && half_tick && stall_en
                       && (bit_idx == data_bits - 4'h1); // R4

  // shifter state machine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= smc_pkg::SMC_IDLE;
      bit_idx <= 4'h0;
      scl_out <= 1'b1;
      scl_oe <= 1'b0;
    end else begin
      unique case (state)
        smc_pkg::SMC_IDLE: begin
          bit_idx <= 4'h0;
          scl_out <= 1'b1;
          scl_oe <= 1'b0;
          if (start_req) begin
            state <= smc_pkg::SMC_LOW;
            scl_out <= 1'b0;
            scl_oe <= 1'b1;
          end
        end
        smc_pkg::SMC_LOW: begin
          if (half_tick) begin
            state <= smc_pkg::SMC_HIGH;
            scl_out <= 1'b1;
          end
        end
        smc_pkg::SMC_HIGH: begin
          if (half_tick) begin
            // scl stays high after the final clock so the far side sees no extra rise
            if (last_bit) begin
              state <= smc_pkg::SMC_DONE; // R6
            end else if (stall_enter) begin
              scl_out <= 1'b0;
              state <= smc_pkg::SMC_STALL; // R4
              bit_idx <= bit_idx + 4'h1;
            end else begin
              scl_out <= 1'b0;
              state <= smc_pkg::SMC_LOW;
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        smc_pkg::SMC_STALL: begin
          scl_out <= 1'b0;
          if (!transfer_irq_flag) begin
            state <= smc_pkg::SMC_LOW; // R5
          end
        end
        smc_pkg::SMC_DONE: begin
          scl_out <= 1'b1;
          scl_oe <= 1'b0;
          state <= smc_pkg::SMC_IDLE;
        end
      endcase
    end
  end

  // data shifter and sda drive
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift <= 8'h00;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end else if (wr && mode_ok && addr == `SMC_OFF_DATA && state == smc_pkg::SMC_IDLE) begin
      shift <= wdata;
    end else if (state == smc_pkg::SMC_LOW && !half_tick) begin
      if (bit_idx < data_bits) begin
        sda_out <= bit_order_select ? shift[0] : shift[7]; // R2
        sda_oe <= 1'b1;
      end else begin
        sda_out <= 1'b1;
        sda_oe <= 1'b0;
      end
    end else if (state == smc_pkg::SMC_HIGH && half_tick) begin
      if (bit_order_select) begin
        shift <= {sda_in, shift[7:1]}; // R2
      end else begin
        shift <= {shift[6:0], sda_in};
      end
    end else if (state == smc_pkg::SMC_DONE) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b1;
    end
  end

  // transfer flag: set wins over the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      transfer_irq_flag <= 1'b0;
    end else if (xfer_done || stall_enter) begin
      transfer_irq_flag <= 1'b1; // R7
    end else if (clr_flag) begin
      transfer_irq_flag <= 1'b0; // R5
    end
  end

  assign events[`SMC_ST_XFER] = xfer_done;
  assign events[`SMC_ST_STALL] = stall_enter;
  assign events[`SMC_ST_DENIED] = (wr || rd) && (addr == `SMC_OFF_MODE) && !iface_enable;

  // sticky status, write one to clear; set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
    end else begin
      for (int i = 0; i < `SMC_ST_W; i++) begin
        if (events[i]) begin
          status[i] <= 1'b1;
        end else if (wr && addr == `SMC_OFF_STAT && wdata[i]) begin
          status[i] <= 1'b0;
        end
      end
      if (wr && addr == `SMC_OFF_MASK) begin
        mask <= wdata[`SMC_ST_W-1:0];
      end
      irq <= |(status & mask);
    end
  end

  // read mux
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr)
      `SMC_OFF_MODE: next_rdata = mode_ok ? serial_mode_config : 8'h00; // R1
      `SMC_OFF_CTRL: next_rdata = {bus_control_reg[7:3], transfer_irq_flag,
                                   bus_control_reg[1:0]};
      `SMC_OFF_EXT: next_rdata = timer_serial_ctrl_reg;
      `SMC_OFF_STAT: next_rdata = {5'h00, status};
      `SMC_OFF_MASK: next_rdata = {5'h00, mask};
      `SMC_OFF_DATA: next_rdata = mode_ok ? shift : 8'h00;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

/* verification/smc_top_properties.sv */
/* port checker for the serial mode block.
   assumes the smc_top ports and register offsets. */
`timescale 1ns/1ps
module smc_top_properties (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // serial clock and interrupt
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic irq
);
  logic en;
  logic [7:0] mode;
  logic [7:0] mask;
  wire start = wr && addr == 4'h1 && wdata[7] && wdata[1];
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // shadow copies of the writable fields
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en <= 1'b0;
      mode <= 8'h00;
      mask <= 8'h00;
    end else if (wr) begin
      if (addr == 4'h1) en <= wdata[7];
      if (addr == 4'h0 && en) mode <= wdata;
      if (addr == 4'h4) mask <= wdata;
    end
  end
  chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("rdata not zero");
  chk_refused_read: assert property (rd && addr == 4'h0 && !en |=> rdata == 8'h00)
    else $error("refused read not zero");
  chk_mode_readback: assert property (rd && addr == 4'h0 && en |=> rdata == mode)
    else $error("mode readback wrong");
  chk_mask_readback:
    assert property (rd && addr == 4'h4 |=> rdata[2:0] == mask[2:0])
    else $error("mask readback wrong");
  chk_start_cause: assert property ($rose(scl_oe) |-> $past(start))
    else $error("frame without start");
  chk_half_min:
    assert property (scl_oe && $past(scl_oe) && $changed(scl_out) |=> $stable(scl_out)[*8])
    else $error("scl half period short");
  chk_irq_source: assert property ($rose(irq) |-> ($past(mask) & 8'h07) != 8'h00)
    else $error("irq with empty mask");
  chk_irq_masked:
    assert property (wr && addr == 4'h4 && wdata == 8'h00 ##1 !(wr && addr == 4'h4) |=> ##1 !irq)
    else $error("irq while masked");
  cover property ($rose(irq));
  cover property (rd && addr == 4'h0 && en);
  cover property ($fell(scl_oe));
endmodule
bind smc_top smc_top_properties u_smc_top_properties (.clk(clk), .arst_n(arst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq));

/* verification/smc_bus_device.sv */
/* bus device model: samples sda on scl rise, acks the ninth bit.
   assumes a pulled-up wired bus. */
`timescale 1ns/1ps
module smc_bus_device (
  // bus wires
  input wire logic scl,
  input wire logic sda,
  // frame restart
  input wire logic clr,
  // ack drive and capture
  output logic sda_low,
  output logic [15:0] bits,
  output logic [4:0] cnt
);
  always @(posedge scl or posedge clr) begin
    if (clr) begin
      bits <= 16'h0000;
      cnt <= 5'h00;
    end else begin
      bits <= {bits[14:0], sda};
      cnt <= cnt + 5'h01;
    end
  end
  // pull sda low across the acknowledge clock
  always @(negedge scl or posedge clr) begin
    if (clr) sda_low <= 1'b0;
    else sda_low <= cnt == 5'h08;
  end
endmodule

/* verification/i2c_mode_register_control_tb.sv */
/* self-checking bench of the serial mode block.
   assumes the design files and the bus device model. */
`timescale 1ns/1ps
module i2c_mode_register_control_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic clr = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, dat, rev;
  logic scl_out, scl_oe, sda_out, sda_oe, irq, dev_low;
  logic [15:0] dev_bits;
  logic [4:0] dev_cnt;
  logic [31:0] seed = 32'h7c5e9494;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int tests_run = 0;
  time t_prev, t_last;
  int div_tab[16] = '{28, 40, 48, 64, 80, 100, 112, 128, 56, 80, 96, 128, 160, 200, 224, 256};
  wire scl_w = scl_oe ? scl_out : 1'b1;
  wire sda_w = (sda_oe ? sda_out : 1'b1) & ~dev_low;
  always #25 clk = ~clk;
  always @(posedge scl_w) begin
    t_prev <= t_last;
    t_last <= $time;
  end
  smc_top u_smc_top (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  smc_bus_device u_smc_bus_device (.scl(scl_w), .sda(sda_w), .clr(clr), .sda_low(dev_low),
    .bits(dev_bits), .cnt(dev_cnt));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    tests_run++;
    if (seen !== expv) begin
      mismatches++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, expv);
    end
  endtask
  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one register cycle; a read notes its expected data
  task automatic io(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= r;
    if (r) exp_q.push_back(d);
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    repeat (n) io(4'h0, 8'h00, 1'b0, 1'b0);
    #1;
  endtask
  task automatic wait_irq();
    idle(2);
    for (int i = 0; i < 4000 && irq !== 1'b1; i++) io(4'h0, 8'h00, 1'b0, 1'b0);
    check(16'(irq), 16'h0001);
  endtask
  task automatic frame(input logic [7:0] md, input logic [7:0] ct);
    seed = lfsr(seed);
    dat = seed[7:0];
    rev = {<<{dat}};
    io(4'h0, md, 1'b1, 1'b0);
    io(4'h5, dat, 1'b1, 1'b0);
    io(4'h3, 8'hff, 1'b1, 1'b0);
    io(4'h1, ct & 8'hfd, 1'b1, 1'b0);
    clr <= 1'b1;
    io(4'h1, ct, 1'b1, 1'b0);
    clr <= 1'b0;
    wait_irq();
  endtask
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) check(16'(rdata), 16'(exp_q.pop_front()));
  end
  initial begin
    #3000000;
    mismatches++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    clr <= 1'b0;
    @(posedge clk);
    io(4'h0, 8'h00, 1'b0, 1'b1);
    io(4'h0, 8'hff, 1'b1, 1'b0);
    io(4'h3, 8'h04, 1'b0, 1'b1);
    io(4'h3, 8'hff, 1'b1, 1'b0);
    io(4'h1, 8'h80, 1'b1, 1'b0);
    io(4'h0, 8'h00, 1'b0, 1'b1);
    seed = lfsr(seed);
    io(4'h0, seed[15:8], 1'b1, 1'b0);
    io(4'h0, seed[15:8], 1'b0, 1'b1);
    io(4'hf, 8'hff, 1'b1, 1'b0);
    io(4'hf, 8'h00, 1'b0, 1'b1);
    io(4'h4, 8'h03, 1'b1, 1'b0);
    io(4'h4, 8'h03, 1'b0, 1'b1);
    // codes in both formats; stall bit set only in the synchronous format
    for (int c = 0; c < 16; c++) begin
      frame({c[3], c[3], 3'h0, c[2:0]}, {7'h51, c[3]});
      check(16'(dev_cnt), 16'((c[2:0] == 3'h0 ? 8 : c[2:0]) + (c[3] ? 0 : 1)));
      io(4'h3, 8'h01, 1'b0, 1'b1);
      if (c == 0) check(dev_bits, {7'h00, dat, 1'b0});
      if (c == 8) check(dev_bits, {8'h00, rev});
    end
    frame(8'h40, 8'ha2);
    idle(20);
    check(16'(scl_w), 16'h0000);
    check(16'(dev_cnt), 16'h0008);
    io(4'h3, 8'h02, 1'b0, 1'b1);
    io(4'h1, 8'ha4, 1'b0, 1'b1);
    io(4'h3, 8'hff, 1'b1, 1'b0);
    io(4'h1, 8'ha0, 1'b1, 1'b0);
    wait_irq();
    check(16'(dev_cnt), 16'h0009);
    io(4'h4, 8'h00, 1'b1, 1'b0);
    idle(2);
    check(16'(irq), 16'h0000);
    io(4'h4, 8'h03, 1'b1, 1'b0);
    idle(2);
    check(16'(irq), 16'h0001);
    io(4'h3, 8'h01, 1'b1, 1'b0);
    idle(2);
    check(16'(irq), 16'h0000);
    for (int r = 0; r < 16; r++) begin
      io(4'h2, {7'h00, r[3]}, 1'b1, 1'b0);
      frame({2'b00, r[2:0], 3'b001}, 8'ha2);
      check(16'((t_last - t_prev) / 50), 16'(div_tab[r]));
    end
    arst_n <= 1'b0;
    idle(2);
    arst_n <= 1'b1;
    io(4'h1, 8'h80, 1'b1, 1'b0);
    io(4'h0, 8'h00, 1'b0, 1'b1);
    idle(3);
    summarize();
  end
endmodule
